// ### logic/fwp_pkg.sv
// Package for the serial memory write-protect controller
//
// Notes on behaviour
// - Write enable latch comes up cleared after reset.
// - Set-latch command sets the latch, shown as status bit 1.
// - Status write data never changes the write enable flag.
// - Chip select rise after clear-latch, status write or memory write clears latch.
// - Clear-latch command resets the latch; status then reads flag zero.
// - Status bits 0, 4, 5, 6 read zero and ignore writes.
// - Bit 7 pin enable, bits 3:2 block guard, bit 1 flag; flag resets zero, bits 7 and 3:2 reload from store.
// - Block guard bits are held in storage that survives power loss.
// - Guard 00 none, 01 3000h-3FFFh, 10 2000h-3FFFh, 11 everything.
// - With pin enable set, protect pin low blocks status writes.
// - Protect pin never blocks memory array writes.
// - Status read returns exactly one status byte on serial output.
// - Memory write takes two address bytes; top two bits ignored.
// - Each data byte goes to incremented address; 3FFFh wraps to 0000h.
// - Data shifts most significant bit first; chip select rise ends write.
// - Burst reaching protected address stops address and drops later bytes.
// - Each byte is committed once its eighth bit arrives.
// - A partially shifted byte never reaches the array.
// - Codes: set-latch 06h, clear-latch 04h, memory write 02h.
// - Codes: status read 05h, status write 01h.
// - First byte after select is the command; sample rising, drive falling.
`default_nettype none

package fwp_pkg;

    localparam int ADDR_W = 14;
    localparam int FIFO_DEPTH = 32;

    // Command codes
    localparam logic [7:0] CMD_SET_LATCH = 8'h06;
    localparam logic [7:0] CMD_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h02;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;

    // Status register fields
    localparam int ST_PIN_EN_BIT = 7;
    localparam int ST_GUARD_HI_BIT = 3;
    localparam int ST_GUARD_LO_BIT = 2;
    localparam int ST_WEL_BIT = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Protected range starts
    localparam logic [13:0] GUARD_QUARTER_BASE = 14'h3000;
    localparam logic [13:0] GUARD_HALF_BASE = 14'h2000;
    localparam logic [13:0] GUARD_ALL_BASE = 14'h0000;
    localparam logic [13:0] ADDR_LAST = 14'h3fff;
    localparam logic [13:0] ADDR_FIRST = 14'h0000;

    // Bit counter
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    typedef enum logic [2:0] {
        FWP_CMD,
        FWP_ADDR_HI,
        FWP_ADDR_LO,
        FWP_DATA,
        FWP_STATUS_WR,
        FWP_STATUS_RD,
        FWP_IGNORE
    } fwp_state_t;

    // One array write
    typedef struct packed {
        logic [13:0] addr;
        logic [7:0] data;
    } fwp_wr_t;

endpackage : fwp_pkg

`default_nettype wire

// ### logic/fwp_fifo.sv
// Write FIFO between the serial front end and the array port
`timescale 1ns/100ps
`default_nettype none

module fwp_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready_o = (count_ff != (PW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_ff[rd_ptr_ff];

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // ----------------------------------------
    // Pointers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule // fwp_fifo

`default_nettype wire

// ### logic/fwp_ctrl.sv
// Serial write-protect controller: latch, status register, write path
`timescale 1ns/100ps
`default_nettype none

module fwp_ctrl #(
    parameter int FIFO_DEPTH = fwp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic wp_n_i,
    // Array write port
    output logic mem_wr_valid_o,
    input wire logic mem_wr_ready_i,
    output logic [13:0] mem_wr_addr_o,
    output logic [7:0] mem_wr_data_o,
    // Nonvolatile guard bits
    input wire logic [1:0] nv_guard_i,
    input wire logic nv_pin_en_i,
    output logic nv_store_o,
    output logic [1:0] nv_guard_o,
    output logic nv_pin_en_o,
    // Status view
    output logic [7:0] status_o
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] cs_sync_ff;
    logic [1:0] sck_sync_ff;
    logic [1:0] si_sync_ff;
    logic [1:0] wp_sync_ff;
    logic cs_d_ff;
    logic sck_d_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_sync_ff <= 2'h3;
            sck_sync_ff <= 2'h0;
            si_sync_ff <= 2'h0;
            wp_sync_ff <= 2'h3;
            cs_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
        end
        else
        begin
            cs_sync_ff <= {cs_sync_ff[0], cs_n_i};
            sck_sync_ff <= {sck_sync_ff[0], sck_i};
            si_sync_ff <= {si_sync_ff[0], si_i};
            wp_sync_ff <= {wp_sync_ff[0], wp_n_i};
            cs_d_ff <= cs_sync_ff[1];
            sck_d_ff <= sck_sync_ff[1];
        end
    end

    logic cs_n;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic sck_mode3_ff;
    logic first_rise_ff;

    assign cs_n = cs_sync_ff[1];
    assign cs_rise = cs_n && !cs_d_ff;
    assign cs_fall = !cs_n && cs_d_ff;
    assign sck_rise = !cs_n && !cs_d_ff && sck_sync_ff[1] && !sck_d_ff;
    assign sck_fall = !cs_n && !cs_d_ff && !sck_sync_ff[1] && sck_d_ff;

    // ----------------------------------------
    // Bit shifter
    // ----------------------------------------
    logic [2:0] bit_cnt_ff;
    logic [6:0] shift_ff;
    logic [7:0] rx_byte;
    logic byte_done;

    assign rx_byte = {shift_ff, si_sync_ff[1]};
    assign byte_done = sck_rise && (bit_cnt_ff == fwp_pkg::BIT_LAST);

    // Bit counter restarts at each select; partial bytes are dropped
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bit_cnt_ff <= fwp_pkg::BIT_FIRST;
            shift_ff <= 7'h00;
        end
        else if (cs_fall)
        begin
            bit_cnt_ff <= fwp_pkg::BIT_FIRST;
        end
        else if (sck_rise)
        begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_ff <= rx_byte[6:0];
        end
    end

    // Mode 3 idle-high clock: its first falling edge is not a data edge
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sck_mode3_ff <= 1'b0;
            first_rise_ff <= 1'b0;
        end
        else if (cs_fall)
        begin
            sck_mode3_ff <= sck_sync_ff[1];
            first_rise_ff <= 1'b0;
        end
        else if (sck_rise)
        begin
            first_rise_ff <= 1'b1;
        end
    end

    // ----------------------------------------
    // Command state machine
    // ----------------------------------------
    fwp_pkg::fwp_state_t state_ff;
    logic [7:0] cmd_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= fwp_pkg::FWP_CMD;
            cmd_ff <= 8'h00;
        end
        else if (cs_fall || cs_rise)
        begin
            state_ff <= fwp_pkg::FWP_CMD;
            cmd_ff <= 8'h00;
        end
        else if (byte_done)
        begin
            unique case (state_ff)
                fwp_pkg::FWP_CMD:
                begin
                    cmd_ff <= rx_byte;
                    unique case (rx_byte)
                        fwp_pkg::CMD_MEM_WRITE:
                            state_ff <= fwp_pkg::FWP_ADDR_HI;
                        fwp_pkg::CMD_STATUS_WRITE:
                            state_ff <= fwp_pkg::FWP_STATUS_WR;
                        fwp_pkg::CMD_STATUS_READ:
                            state_ff <= fwp_pkg::FWP_STATUS_RD;
                        default:
                            state_ff <= fwp_pkg::FWP_IGNORE;
                    endcase
                end
                fwp_pkg::FWP_ADDR_HI:
                    state_ff <= fwp_pkg::FWP_ADDR_LO;
                fwp_pkg::FWP_ADDR_LO:
                    state_ff <= fwp_pkg::FWP_DATA;
                fwp_pkg::FWP_STATUS_WR:
                    state_ff <= fwp_pkg::FWP_IGNORE;
                fwp_pkg::FWP_STATUS_RD:
                    state_ff <= fwp_pkg::FWP_IGNORE;
                fwp_pkg::FWP_DATA:
                    state_ff <= fwp_pkg::FWP_DATA;
                fwp_pkg::FWP_IGNORE:
                    state_ff <= fwp_pkg::FWP_IGNORE;
            endcase
        end
    end

    // ----------------------------------------
    // Status register and latch
    // ----------------------------------------
    logic wel_ff;
    logic pin_en_ff;
    logic [1:0] guard_ff;
    logic guard_loaded_ff;
    logic status_wr_ok;
    logic latch_clear_cmd;

    assign status_wr_ok = wel_ff && !(pin_en_ff && !wp_sync_ff[1]);
    assign latch_clear_cmd = (cmd_ff == fwp_pkg::CMD_CLEAR_LATCH)
        || (cmd_ff == fwp_pkg::CMD_STATUS_WRITE)
        || (cmd_ff == fwp_pkg::CMD_MEM_WRITE);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wel_ff <= 1'b0;
        end
        else if (cs_rise && latch_clear_cmd)
        begin
            wel_ff <= 1'b0;
        end
        else if (byte_done && state_ff == fwp_pkg::FWP_CMD
            && rx_byte == fwp_pkg::CMD_SET_LATCH)
        begin
            wel_ff <= 1'b1;
        end
    end

    // Guard bits reload from nonvolatile store after reset
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_en_ff <= 1'b0;
            guard_ff <= 2'h0;
            guard_loaded_ff <= 1'b0;
        end
        else if (!guard_loaded_ff)
        begin
            pin_en_ff <= nv_pin_en_i;
            guard_ff <= nv_guard_i;
            guard_loaded_ff <= 1'b1;
        end
        else if (byte_done && state_ff == fwp_pkg::FWP_STATUS_WR
            && status_wr_ok)
        begin
            pin_en_ff <= rx_byte[fwp_pkg::ST_PIN_EN_BIT];
            guard_ff <= {rx_byte[fwp_pkg::ST_GUARD_HI_BIT],
                rx_byte[fwp_pkg::ST_GUARD_LO_BIT]};
        end
    end

    // Store strobe, one cycle, with the value just written
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            nv_store_o <= 1'b0;
        end
        else
        begin
            nv_store_o <= guard_loaded_ff && byte_done
                && state_ff == fwp_pkg::FWP_STATUS_WR && status_wr_ok;
        end
    end

    assign nv_guard_o = guard_ff;
    assign nv_pin_en_o = pin_en_ff;

    // Fixed zero bits, field placement
    assign status_o = {pin_en_ff, 3'h0, guard_ff, wel_ff, 1'b0};

    // ----------------------------------------
    // Status read output
    // ----------------------------------------
    logic [7:0] tx_ff;
    logic so_oe_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_ff <= 8'h00;
            so_oe_ff <= 1'b0;
        end
        else if (cs_n)
        begin
            so_oe_ff <= 1'b0;
        end
        else if (byte_done && state_ff == fwp_pkg::FWP_CMD
            && rx_byte == fwp_pkg::CMD_STATUS_READ)
        begin
            tx_ff <= status_o;
            so_oe_ff <= 1'b0;
        end
        else if (sck_fall && (first_rise_ff || !sck_mode3_ff))
        begin
            if (state_ff == fwp_pkg::FWP_STATUS_RD)
            begin
                so_oe_ff <= (bit_cnt_ff == fwp_pkg::BIT_FIRST)
                    ? 1'b1 : so_oe_ff;
                tx_ff <= (bit_cnt_ff == fwp_pkg::BIT_FIRST)
                    ? tx_ff : {tx_ff[6:0], 1'b0};
            end
            else
            begin
                so_oe_ff <= 1'b0;
            end
        end
    end

    assign so_o = tx_ff[7];
    assign so_oe_o = so_oe_ff;

    // ----------------------------------------
    // Memory write path
    // ----------------------------------------
    logic [13:0] addr_ff;
    logic [5:0] addr_hi_ff;
    logic halted_ff;
    logic addr_guarded;
    logic push_valid;
    logic push_ready;
    fwp_pkg::fwp_wr_t push_word;
    fwp_pkg::fwp_wr_t pop_word;

    // Protected range by guard setting
    always_comb
    begin
        unique case (guard_ff)
            2'h0: addr_guarded = 1'b0;
            2'h1: addr_guarded = addr_ff >= fwp_pkg::GUARD_QUARTER_BASE;
            2'h2: addr_guarded = addr_ff >= fwp_pkg::GUARD_HALF_BASE;
            2'h3: addr_guarded = addr_ff >= fwp_pkg::GUARD_ALL_BASE;
        endcase
    end

    // Protect pin takes no part here
    assign push_valid = byte_done && state_ff == fwp_pkg::FWP_DATA
        && wel_ff && !halted_ff && !addr_guarded;
    assign push_word.addr = addr_ff;
    assign push_word.data = rx_byte;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_ff <= fwp_pkg::ADDR_FIRST;
            addr_hi_ff <= 6'h00;
            halted_ff <= 1'b0;
        end
        else if (cs_fall)
        begin
            halted_ff <= 1'b0;
        end
        else if (byte_done)
        begin
            if (state_ff == fwp_pkg::FWP_ADDR_HI)
            begin
                addr_hi_ff <= rx_byte[5:0];
            end
            else if (state_ff == fwp_pkg::FWP_ADDR_LO)
            begin
                addr_ff <= {addr_hi_ff, rx_byte};
            end
            else if (state_ff == fwp_pkg::FWP_DATA)
            begin
                if (addr_guarded || halted_ff || !push_ready)
                begin
                    halted_ff <= 1'b1;
                end
                else
                begin
                    addr_ff <= (addr_ff == fwp_pkg::ADDR_LAST)
                        ? fwp_pkg::ADDR_FIRST : addr_ff + 14'h0001;
                end
            end
        end
    end

    fwp_fifo #(
        .WIDTH($bits(fwp_pkg::fwp_wr_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_word),
        .out_valid_o(mem_wr_valid_o),
        .out_ready_i(mem_wr_ready_i),
        .out_data_o(pop_word)
    );

    assign mem_wr_addr_o = pop_word.addr;
    assign mem_wr_data_o = pop_word.data;

endmodule // fwp_ctrl

`default_nettype wire

// ### tb/fwp_ctrl_properties.sv
// Port-level checks for the write-protect controller
`timescale 1ns/100ps
`default_nettype none

module fwp_ctrl_properties #(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic so_oe_o,
    input wire logic wp_n_i,
    // Array write port
    input wire logic mem_wr_valid_o,
    input wire logic mem_wr_ready_i,
    input wire logic [13:0] mem_wr_addr_o,
    input wire logic [7:0] mem_wr_data_o,
    // Guard store and status
    input wire logic nv_store_o,
    input wire logic [1:0] nv_guard_o,
    input wire logic nv_pin_en_o,
    input wire logic [7:0] status_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    fixed_bits_a: assert property (status_o[0] == 1'b0 && status_o[6:4] == 3'h0)
        else $error("reserved status bits not zero");
    field_view_a: assert property ($changed(status_o[7:2]) |->
        nv_store_o || $past(rst_i, 2))
        else $error("status fields changed without a store");
    store_pulse_a: assert property (nv_store_o |=> !nv_store_o)
        else $error("store strobe longer than one cycle");
    store_latch_a: assert property (nv_store_o |-> $past(status_o[1]))
        else $error("status stored without write enable");
    store_pin_a: assert property (nv_store_o |-> wp_n_i || !$past(nv_pin_en_o, 2))
        else $error("status stored while pin protected");
    so_idle_a: assert property (cs_n_i [*8] |-> !so_oe_o)
        else $error("serial output driven while deselected");
    wel_set_a: assert property ($rose(status_o[1]) |-> !$past(cs_n_i, 2))
        else $error("write enable set outside a select");
    wel_clear_a: assert property ($fell(status_o[1]) |-> cs_n_i)
        else $error("write enable cleared before select end");
    wr_hold_a: assert property (mem_wr_valid_o && !mem_wr_ready_i |=>
        mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o))
        else $error("array write changed before taken");
    guard_range_a: assert property (mem_wr_valid_o |-> !(nv_guard_o == 2'h3 ||
        (nv_guard_o == 2'h2 && mem_wr_addr_o[13]) ||
        (nv_guard_o == 2'h1 && mem_wr_addr_o[13:12] == 2'h3)))
        else $error("array write inside guarded range");
endmodule // fwp_ctrl_properties

`default_nettype wire

// ### tb/fwp_spi_master.sv
// Serial bus master model for the controller pins
`timescale 1ns/100ps
`default_nettype none

module fwp_spi_master (
    // Clock
    input wire logic clk_i,
    // Serial pins
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i
);
    logic [7:0] tx_q [$];
    logic [7:0] rx_q [$];
    logic idle_hi = 1'b0;

    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    // One select cycle of nbits bits, clock idles at idle_hi
    task automatic frame(input int nbits);
        logic [7:0] b;
        b = 8'h00;
        rx_q = {};
        @(negedge clk_i);
        sck_o <= idle_hi;
        cs_n_o <= 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < nbits; i++)
        begin
            si_o <= tx_q[i / 8][7 - (i % 8)];
            sck_o <= 1'b0;
            repeat (4) @(negedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(negedge clk_i);
            b = {b[6:0], so_i};
            if (i % 8 == 7)
                rx_q.push_back(b);
        end
        sck_o <= idle_hi;
        repeat (4) @(negedge clk_i);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        repeat (16) @(negedge clk_i);
    endtask
endmodule // fwp_spi_master

`default_nettype wire

// ### tb/tb_top.sv
// Top-level bench for the write-protect controller
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam int DEPTH = 32;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, sck, si, so, so_oe, so_line, wp_n = 1'b1;
    logic wr_valid, wr_ready = 1'b1, nv_store, nv_pin, pin_q = 1'b0;
    logic [13:0] wr_addr;
    logic [7:0] wr_data, status;
    logic [1:0] nv_guard, guard_q = 2'h0;
    logic [7:0] mem [16384];
    int n_fail = 0, samples_checked = 0, n_wr = 0, cycles = 0;

    always #25 clk_sys_i = ~clk_sys_i;
    assign so_line = so_oe ? so : 1'bz;

    fwp_spi_master u_master (.clk_i(clk_sys_i), .cs_n_o(cs_n),
        .sck_o(sck), .si_o(si), .so_i(so_line));

    fwp_ctrl #(.FIFO_DEPTH(DEPTH)) DUT (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so),
        .so_oe_o(so_oe), .wp_n_i(wp_n), .mem_wr_valid_o(wr_valid),
        .mem_wr_ready_i(wr_ready), .mem_wr_addr_o(wr_addr),
        .mem_wr_data_o(wr_data), .nv_guard_i(guard_q),
        .nv_pin_en_i(pin_q), .nv_store_o(nv_store),
        .nv_guard_o(nv_guard), .nv_pin_en_o(nv_pin), .status_o(status));

    // Array sink and guard store
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
        begin
            mem[wr_addr] = wr_data;
            n_wr = n_wr + 1;
        end
        if (nv_store === 1'b1)
        begin
            guard_q <= nv_guard;
            pin_q <= nv_pin;
        end
    end

    always @(negedge clk_sys_i)
        if (cycles == 40000)
        begin
            n_fail = n_fail + 1;
            end_sim();
        end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] c, input logic [7:0] d,
        input int nbits);
        u_master.tx_q = {c, d, 8'h00};
        u_master.frame(nbits);
    endtask

    task automatic rd(input logic [7:0] exp);
        send(8'h05, 8'h00, 24);
        chk(u_master.rx_q[1], exp);
    endtask

    task automatic wr(input logic [15:0] a, input int n, input int extra);
        u_master.tx_q = {8'h02, a[15:8], a[7:0]};
        for (int k = 0; k < n; k++)
            u_master.tx_q.push_back(8'ha0 + k[7:0]);
        u_master.tx_q.push_back(8'h5a);
        u_master.frame(24 + 8 * n + extra);
    endtask

    function automatic bit guarded(input int a, input int g);
        return g == 3 || (g == 2 && a >= 'h2000) || (g == 1 && a >= 'h3000);
    endfunction

    task automatic t_latch();
        rd(8'h00);
        chk(status, 8'h00);
        send(8'h06, 8'h00, 8);
        rd(8'h02);
        chk(u_master.rx_q[2], 8'hzz);
        send(8'h04, 8'h00, 8);
        rd(8'h00);
        send(8'h01, 8'h0c, 16);
        rd(8'h00);
        u_master.idle_hi = 1'b1;
        send(8'h06, 8'h00, 8);
        rd(8'h02);
        send(8'h04, 8'h00, 8);
        u_master.idle_hi = 1'b0;
        rd(8'h00);
    endtask

    task automatic t_mem();
        int base;
        base = n_wr;
        wr(16'h0010, 1, 0);
        chk(n_wr - base, 0);
        wp_n = 1'b0;
        send(8'h06, 8'h00, 8);
        wr(16'hfffe, 3, 5);
        chk(n_wr - base, 3);
        chk(mem[14'h3ffe], 8'ha0);
        chk(mem[14'h0000], 8'ha2);
        rd(8'h00);
        wp_n = 1'b1;
    endtask

    task automatic t_guard();
        int base, exp_n;
        for (int g = 0; g < 4; g++)
        begin
            send(8'h06, 8'h00, 8);
            send(8'h01, {4'h0, g[1:0], 2'h0}, 16);
            rd({4'h0, g[1:0], 2'h0});
            exp_n = 0;
            while (exp_n < 4 && !guarded('h2ffe + exp_n, g))
                exp_n++;
            base = n_wr;
            send(8'h06, 8'h00, 8);
            wr(16'h2ffe, 4, 0);
            chk(n_wr - base, exp_n);
        end
        send(8'h06, 8'h00, 8);
        send(8'h01, 8'h00, 16);
    endtask

    task automatic t_pin();
        wp_n = 1'b0;
        send(8'h06, 8'h00, 8);
        send(8'h01, 8'hf3, 16);
        rd(8'h80);
        send(8'h06, 8'h00, 8);
        wr(16'h0200, 1, 0);
        chk(mem[14'h0200], 8'ha0);
        send(8'h06, 8'h00, 8);
        send(8'h01, 8'h0c, 16);
        rd(8'h80);
        chk({pin_q, guard_q}, 3'h4);
        wp_n = 1'b1;
        send(8'h06, 8'h00, 8);
        send(8'h01, 8'h00, 16);
        rd(8'h00);
    endtask

    task automatic t_fifo();
        int base;
        base = n_wr;
        wr_ready = 1'b0;
        send(8'h06, 8'h00, 8);
        wr(16'h0100, DEPTH + 2, 0);
        chk(wr_valid, 1'b1);
        wr_ready = 1'b1;
        repeat (DEPTH + 4) @(negedge clk_sys_i);
        chk(n_wr - base, DEPTH);
        chk(mem[14'h011f], 8'ha0 + DEPTH - 1);
        chk(wr_valid, 1'b0);
    endtask

    task automatic t_nv();
        send(8'h06, 8'h00, 8);
        send(8'h01, 8'h08, 16);
        rst_i = 1'b1;
        repeat (20) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        rd(8'h08);
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        t_latch();
        t_mem();
        t_guard();
        t_pin();
        t_fifo();
        t_nv();
        end_sim();
    end
endmodule // tb_top

bind fwp_ctrl fwp_ctrl_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
    .so_oe_o(so_oe_o), .wp_n_i(wp_n_i), .mem_wr_valid_o(mem_wr_valid_o),
    .mem_wr_ready_i(mem_wr_ready_i), .mem_wr_addr_o(mem_wr_addr_o),
    .mem_wr_data_o(mem_wr_data_o), .nv_store_o(nv_store_o),
    .nv_guard_o(nv_guard_o), .nv_pin_en_o(nv_pin_en_o),
    .status_o(status_o));

`default_nettype wire
